// ### cswm_pkg.sv
// Constants, state encodings and carrier types for the clock switch and fail monitor
package cswm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map and APB carriers
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_OSC_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_RC_TRIM = 12'h004;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } cswm_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cswm_apb_rsp_t;

  ////////////////////////////////////////////////////////////////////////////
  // Asynchronous status pins from oscillators, timers and power control
  typedef struct packed {
    logic sys_clk_toggle;
    logic low_power_rc_osc_toggle;
    logic target_osc_ready;
    logic sel_osc_started;
    logic pll_lock;
    logic power_up_timer_expired;
    logic sleep_mode;
  } cswm_osc_pins_t;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions in oscillator_control and fast_rc_trim
  localparam int CTRL_CURRENT_OSC_GROUP_LSB = 12;
  localparam int CTRL_NEW_OSC_GROUP_LSB = 8;
  localparam int CTRL_CLOCK_POSTSCALE_SEL_LSB = 6;
  localparam int CTRL_LOCK_BIT = 5;
  localparam int CTRL_CF_BIT = 3;
  localparam int CTRL_SECONDARY_OSC_ENABLE_BIT = 1;
  localparam int CTRL_OSC_SWITCH_REQUEST_BIT = 0;
  localparam int GRP_W = 3;
  localparam int TRIM_W = 4;
  localparam int LANE_W = 8;
  localparam int LANE_HI = 1;
  localparam int LANE_LO = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Group codes, configuration codes, keys, reset values
  localparam logic [GRP_W-1:0] GRP_PLL = 3'h7;
  localparam logic [GRP_W-1:0] GRP_EXT = 3'h3;
  localparam logic [GRP_W-1:0] GRP_LOW_POWER_RC_OSC = 3'h2;
  localparam logic [GRP_W-1:0] GRP_FRC = 3'h1;
  localparam logic [GRP_W-1:0] GRP_LPXT = 3'h0;
  localparam logic [1:0] SMC_SW_AND_MON = 2'h0;
  localparam int SMC_OFF_BIT = 1;
  localparam logic [1:0][7:0] UNLOCK_KEY1 = {8'h78, 8'h46};
  localparam logic [1:0][7:0] UNLOCK_KEY2 = {8'h9a, 8'h57};
  localparam logic [1:0] RST_CLOCK_POSTSCALE_SEL = 2'h0;
  localparam logic [TRIM_W-1:0] RST_TRIM = 4'h0;
  localparam logic [GRP_W-1:0] RST_GROUP = 3'h1;
  localparam int FAIL_WINDOW_DEF = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Postscaler codes and divide ratios
  localparam int DIV_W = 7;
  localparam logic [1:0] CLOCK_POSTSCALE_SEL_DIV64 = 2'h3;
  localparam logic [1:0] CLOCK_POSTSCALE_SEL_DIV16 = 2'h2;
  localparam logic [1:0] CLOCK_POSTSCALE_SEL_DIV4 = 2'h1;
  localparam logic [DIV_W-1:0] DIV_64 = 7'h40;
  localparam logic [DIV_W-1:0] DIV_16 = 7'h10;
  localparam logic [DIV_W-1:0] DIV_4 = 7'h04;
  localparam logic [DIV_W-1:0] DIV_1 = 7'h01;

  ////////////////////////////////////////////////////////////////////////////
  // State encodings
  typedef enum logic [1:0] {
    UL_IDLE = 2'b00,
    UL_KEY1 = 2'b01,
    UL_OPEN = 2'b10
  } cswm_unlock_t;

  typedef enum logic {
    SW_IDLE = 1'b0,
    SW_WAIT = 1'b1
  } cswm_sw_state_t;

endpackage

// ### cswm_top.sv
// Clock group switching, fail-safe clock monitor and oscillator control registers
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R01: Monitor on keeps low-power RC running except Sleep
// R02: Failure raises trap and selects fast RC
// R03: Forced switch loads fast RC, sets fail, clears request
// R04: Failure leaves watchdog clock untouched
// R05: Oscillator not started at timer expiry means failure
// R06: Switch only between groups; primary follows config
// R07: Reset loads current and new group from config
// R08: Request bit starts switch; clearing it aborts
// R09: Config code 1x disables switching and monitor
// R10: Switching disabled: config selects, current only reports
// R11: Software avoids clocks below 100 kHz when monitored
// R12: Low byte write needs 0x46 then 0x57
// R13: High byte write needs 0x78 then 0x9A
// R14: Group codes fixed; current takes new on success
// R15: Postscaler divides by 1, 4, 16, 64
// R16: Lock flag follows PLL lock, only when PLL
// R17: Fail flag sets on failure, cleared on start
// R18: Secondary enable bit drives secondary oscillator
// R19: Request bit clears on success, redundant, forced switch
// R20: Signed four-bit trim field, resets to zero
// R21: Config 00 monitor on, 01 monitor off
// R22: Secondary is device clock for group 000 enabled
// R23: No system clock edge within window is failure
// R24: Control register writes without complete unlock are ignored
module cswm_top #(
  parameter int unsigned FAIL_WINDOW_TICKS = cswm_pkg::FAIL_WINDOW_DEF
) (
  // Clock and power-on/brown-out reset
  input wire logic mclk,
  input wire logic arst_n,
  // APB slave
  input wire cswm_pkg::cswm_apb_req_t apb_req,
  output cswm_pkg::cswm_apb_rsp_t apb_rsp,
  // Configuration fuses
  input wire logic [1:0] switch_monitor_cfg,
  input wire logic [cswm_pkg::GRP_W-1:0] poweron_group_cfg,
  input wire logic [4:0] primary_select_cfg,
  input wire logic soft_watchdog_enable,
  // Oscillator and timer status pins
  input wire cswm_pkg::cswm_osc_pins_t osc_pins,
  // Clock control outputs
  output logic [cswm_pkg::GRP_W-1:0] osc_group_sel,
  output logic [cswm_pkg::GRP_W-1:0] target_osc_group,
  output logic [4:0] primary_select_out,
  output logic osc_switch_busy,
  output logic [1:0] clock_postscale_sel,
  output logic [cswm_pkg::DIV_W-1:0] postscale_divisor,
  output logic secondary_osc_on,
  output logic secondary_is_devclk,
  output logic low_power_rc_osc_run,
  output logic clk_fail_trap,
  output logic signed [cswm_pkg::TRIM_W-1:0] rc_trim_out
);
  import cswm_pkg::*;

  localparam int WCNT_W = $clog2(FAIL_WINDOW_TICKS + 1);

  cswm_osc_pins_t sync1_q;
  cswm_osc_pins_t sync2_q;
  cswm_osc_pins_t prev_q;
  logic cfg_loaded_q;
  logic [1:0] smc_q;
  logic [GRP_W-1:0] fos_q;
  logic [4:0] fpr_q;
  logic [GRP_W-1:0] current_osc_group_q;
  logic [GRP_W-1:0] new_osc_group_q;
  logic osc_switch_request_q;
  logic [1:0] clock_postscale_sel_q;
  logic lock_q;
  logic clock_fail_flag_q;
  logic secondary_osc_enable_q;
  logic [TRIM_W-1:0] rc_trim_field_q;
  cswm_sw_state_t sw_st_q;
  cswm_unlock_t ul_q [2];
  logic [1:0] lane_open_wr;
  logic [WCNT_W-1:0] wcnt_q;
  logic xfer;
  logic ctrl_wr;
  logic trim_wr;
  logic [7:0] wlo;
  logic lo_wr;
  logic hi_wr;
  logic sw_en;
  logic mon_en;
  logic mon_active;
  logic sys_edge;
  logic low_power_rc_osc_edge;
  logic fail_clk;
  logic fail_power_up_timer;
  logic fail_evt;
  logic sw_start;
  logic legal_group;
  logic [31:0] rd_data;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= osc_pins;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fuse capture one edge after reset release
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_loaded_q <= 1'b0;
      smc_q <= 2'h3;
      fos_q <= RST_GROUP;
      fpr_q <= 5'h00;
    end else if (!cfg_loaded_q) begin
      cfg_loaded_q <= 1'b1;
      smc_q <= switch_monitor_cfg;
      fos_q <= poweron_group_cfg;
      fpr_q <= primary_select_cfg;
    end
  end

  assign sw_en = cfg_loaded_q && !smc_q[SMC_OFF_BIT]; // R09
  assign mon_en = cfg_loaded_q && (smc_q == SMC_SW_AND_MON); // R21

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; every access answers in its first access cycle
  assign xfer = apb_req.psel && apb_req.penable && apb_rsp.pready;
  assign ctrl_wr = xfer && apb_req.pwrite && (apb_req.paddr == OFS_OSC_CTRL);
  assign trim_wr = xfer && apb_req.pwrite && (apb_req.paddr == OFS_RC_TRIM) && apb_req.pstrb[0];
  assign wlo = apb_req.pwdata[LANE_W-1:0];
  assign lo_wr = lane_open_wr[LANE_LO];
  assign hi_wr = lane_open_wr[LANE_HI];

  always_comb begin
    rd_data = '0;
    if (apb_req.paddr == OFS_OSC_CTRL) begin
      rd_data[CTRL_CURRENT_OSC_GROUP_LSB +: GRP_W] = current_osc_group_q;
      rd_data[CTRL_NEW_OSC_GROUP_LSB +: GRP_W] = new_osc_group_q;
      rd_data[CTRL_CLOCK_POSTSCALE_SEL_LSB +: 2] = clock_postscale_sel_q;
      rd_data[CTRL_LOCK_BIT] = lock_q;
      rd_data[CTRL_CF_BIT] = clock_fail_flag_q;
      rd_data[CTRL_SECONDARY_OSC_ENABLE_BIT] = secondary_osc_enable_q;
      rd_data[CTRL_OSC_SWITCH_REQUEST_BIT] = osc_switch_request_q;
    end else if (apb_req.paddr == OFS_RC_TRIM) begin
      rd_data[TRIM_W-1:0] = rc_trim_field_q;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      apb_rsp <= '0;
    end else if (apb_req.psel && !apb_req.penable) begin
      apb_rsp.pready <= 1'b1;
      apb_rsp.prdata <= apb_req.pwrite ? 32'h0000_0000 : rd_data;
      apb_rsp.pslverr <= (apb_req.paddr != OFS_OSC_CTRL) && (apb_req.paddr != OFS_RC_TRIM);
    end else begin
      apb_rsp <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane unlock: any other transfer in between breaks the sequence
  for (genvar g = 0; g < 2; g++) begin : g_lane
    logic [7:0] lane_byte;
    logic lane_hit;
    assign lane_byte = apb_req.pwdata[g*LANE_W +: LANE_W];
    assign lane_hit = ctrl_wr && apb_req.pstrb[g];
    assign lane_open_wr[g] = lane_hit && (ul_q[g] == UL_OPEN); // R12 R13 R24

    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        ul_q[g] <= UL_IDLE;
      end else if (xfer) begin
        if (!lane_hit) begin
          ul_q[g] <= UL_IDLE; // R24
        end else begin
          case (ul_q[g])
            UL_IDLE: ul_q[g] <= (lane_byte == UNLOCK_KEY1[g]) ? UL_KEY1 : UL_IDLE;
            UL_KEY1: begin
              if (lane_byte == UNLOCK_KEY2[g]) begin
                ul_q[g] <= UL_OPEN; // R12 R13
              end else begin
                ul_q[g] <= (lane_byte == UNLOCK_KEY1[g]) ? UL_KEY1 : UL_IDLE;
              end
            end
            UL_OPEN: ul_q[g] <= UL_IDLE;
            default: ul_q[g] <= UL_IDLE;
          endcase
        end
      end
    end
  end

  AST_LOW_LOCKED: assert property (ctrl_wr && apb_req.pstrb[LANE_LO] && (ul_q[LANE_LO] != UL_OPEN)
      |=> $stable(clock_postscale_sel_q) && $stable(secondary_osc_enable_q)) // R12
    else $error("Locked low byte write changed control");
  AST_HIGH_LOCKED: assert property (ctrl_wr && apb_req.pstrb[LANE_HI] && (ul_q[LANE_HI] != UL_OPEN)
      |=> $stable(new_osc_group_q)) // R13
    else $error("Locked high byte write changed new group");
  AST_OPEN_ONCE: assert property (lo_wr |=> (ul_q[LANE_LO] == UL_IDLE)) // R24
    else $error("Low byte stayed open after one write");

  ////////////////////////////////////////////////////////////////////////////
  // Fail monitor: count low-power RC ticks since the last system clock edge
  assign sys_edge = sync2_q.sys_clk_toggle ^ prev_q.sys_clk_toggle;
  assign low_power_rc_osc_edge = sync2_q.low_power_rc_osc_toggle ^ prev_q.low_power_rc_osc_toggle;
  assign mon_active = mon_en && !sync2_q.sleep_mode;
  assign fail_clk = mon_active && !sys_edge && low_power_rc_osc_edge
      && (wcnt_q == WCNT_W'(FAIL_WINDOW_TICKS - 1)); // R23
  assign fail_power_up_timer = mon_en && sync2_q.power_up_timer_expired && !prev_q.power_up_timer_expired
      && !sync2_q.sel_osc_started; // R05
  assign fail_evt = fail_clk || fail_power_up_timer; // R02

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wcnt_q <= '0;
    end else if (!mon_active || sys_edge || fail_evt) begin
      wcnt_q <= '0;
    end else if (low_power_rc_osc_edge) begin
      wcnt_q <= WCNT_W'(wcnt_q + 1'b1); // R23
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Group switch sequencer
  assign legal_group = (apb_req.pwdata[LANE_W +: GRP_W] == GRP_PLL)
      || (apb_req.pwdata[LANE_W +: GRP_W] == GRP_EXT)
      || (apb_req.pwdata[LANE_W +: GRP_W] == GRP_LOW_POWER_RC_OSC)
      || (apb_req.pwdata[LANE_W +: GRP_W] == GRP_FRC)
      || (apb_req.pwdata[LANE_W +: GRP_W] == GRP_LPXT); // R06 R14
  assign sw_start = sw_en && !fail_evt && (sw_st_q == SW_IDLE) && lo_wr
      && wlo[CTRL_OSC_SWITCH_REQUEST_BIT] && (new_osc_group_q != current_osc_group_q); // R08

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      new_osc_group_q <= RST_GROUP;
    end else if (!cfg_loaded_q) begin
      new_osc_group_q <= poweron_group_cfg; // R07
    end else if (hi_wr && legal_group) begin
      new_osc_group_q <= apb_req.pwdata[LANE_W +: GRP_W]; // R06
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      current_osc_group_q <= RST_GROUP;
      osc_switch_request_q <= 1'b0;
      sw_st_q <= SW_IDLE;
    end else if (!cfg_loaded_q) begin
      current_osc_group_q <= poweron_group_cfg; // R07
    end else if (!sw_en) begin
      current_osc_group_q <= fos_q; // R10
      osc_switch_request_q <= 1'b0; // R09
      sw_st_q <= SW_IDLE;
    end else if (fail_evt) begin
      current_osc_group_q <= GRP_FRC; // R03
      osc_switch_request_q <= 1'b0; // R19
      sw_st_q <= SW_IDLE;
    end else begin
      case (sw_st_q)
        SW_IDLE: begin
          if (sw_start) begin
            osc_switch_request_q <= 1'b1; // R08
            sw_st_q <= SW_WAIT;
          end else if (lo_wr) begin
            osc_switch_request_q <= 1'b0; // R19
          end
        end
        SW_WAIT: begin
          if (lo_wr && !wlo[CTRL_OSC_SWITCH_REQUEST_BIT]) begin
            osc_switch_request_q <= 1'b0; // R08
            sw_st_q <= SW_IDLE;
          end else if (sync2_q.target_osc_ready) begin
            current_osc_group_q <= new_osc_group_q; // R14
            osc_switch_request_q <= 1'b0; // R19
            sw_st_q <= SW_IDLE;
          end
        end
        default: sw_st_q <= SW_IDLE;
      endcase
    end
  end

  AST_FAIL_TO_FRC: assert property (fail_evt && sw_en |=> (current_osc_group_q == GRP_FRC)
      && !osc_switch_request_q && clock_fail_flag_q) // R03
    else $error("Failure did not force fast RC with flag and request clear");
  AST_TRAP_PULSE: assert property (fail_evt |=> clk_fail_trap ##1 !clk_fail_trap) // R02
    else $error("Trap is not a one-cycle pulse after failure");
  AST_ABORT: assert property ((sw_st_q == SW_WAIT) && sw_en && lo_wr && !wlo[CTRL_OSC_SWITCH_REQUEST_BIT]
      |=> (sw_st_q == SW_IDLE) && $stable(current_osc_group_q)) // R08
    else $error("Clearing the request did not abort the switch");
  AST_REDUNDANT: assert property (sw_en && !fail_evt && (sw_st_q == SW_IDLE) && lo_wr
      && (new_osc_group_q == current_osc_group_q) |=> !osc_switch_request_q) // R19
    else $error("Redundant switch left the request set");
  AST_DISABLED: assert property (cfg_loaded_q && !sw_en |=> (current_osc_group_q == fos_q)
      && (sw_st_q == SW_IDLE)) // R10
    else $error("Disabled switching did not follow configuration");
  COV_SWITCH_DONE: cover property ((sw_st_q == SW_WAIT) ##1 (sw_st_q == SW_IDLE)
      && $changed(current_osc_group_q));
  COV_FAIL_WHILE_WAIT: cover property ((sw_st_q == SW_WAIT) && fail_evt);
  COV_POWER_UP_TIMER_FAIL: cover property (fail_power_up_timer);

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; a failure wins over any clear in the same cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      clock_fail_flag_q <= 1'b0;
    end else if (fail_evt) begin
      clock_fail_flag_q <= 1'b1; // R17
    end else if (sw_start || (lo_wr && !wlo[CTRL_CF_BIT])) begin
      clock_fail_flag_q <= 1'b0; // R17
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lock_q <= 1'b0;
    end else if (sw_start) begin
      lock_q <= 1'b0; // R16
    end else begin
      lock_q <= sync2_q.pll_lock && (current_osc_group_q == GRP_PLL); // R16
    end
  end

  AST_LOCK_ONLY_PLL: assert property (lock_q |-> ($past(current_osc_group_q) == GRP_PLL)
      && $past(sync2_q.pll_lock)) // R16
    else $error("Lock flag set without PLL selected and locked");

  ////////////////////////////////////////////////////////////////////////////
  // Plain control fields
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      clock_postscale_sel_q <= RST_CLOCK_POSTSCALE_SEL;
      secondary_osc_enable_q <= 1'b0;
    end else if (lo_wr) begin
      clock_postscale_sel_q <= wlo[CTRL_CLOCK_POSTSCALE_SEL_LSB +: 2]; // R15
      secondary_osc_enable_q <= wlo[CTRL_SECONDARY_OSC_ENABLE_BIT]; // R18
    end
  end

  // Trim needs no unlock; it only nudges the fast RC frequency
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rc_trim_field_q <= RST_TRIM; // R20
    end else if (trim_wr) begin
      rc_trim_field_q <= apb_req.pwdata[TRIM_W-1:0]; // R20
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output register stage
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      osc_group_sel <= RST_GROUP;
      target_osc_group <= RST_GROUP;
      primary_select_out <= 5'h00;
      osc_switch_busy <= 1'b0;
      clock_postscale_sel <= RST_CLOCK_POSTSCALE_SEL;
      postscale_divisor <= DIV_1;
      secondary_osc_on <= 1'b0;
      secondary_is_devclk <= 1'b0;
      low_power_rc_osc_run <= 1'b1;
      clk_fail_trap <= 1'b0;
      rc_trim_out <= RST_TRIM;
    end else begin
      osc_group_sel <= current_osc_group_q;
      target_osc_group <= new_osc_group_q;
      primary_select_out <= fpr_q; // R06
      osc_switch_busy <= (sw_st_q == SW_WAIT);
      clock_postscale_sel <= clock_postscale_sel_q;
      case (clock_postscale_sel_q)
        CLOCK_POSTSCALE_SEL_DIV64: postscale_divisor <= DIV_64; // R15
        CLOCK_POSTSCALE_SEL_DIV16: postscale_divisor <= DIV_16; // R15
        CLOCK_POSTSCALE_SEL_DIV4: postscale_divisor <= DIV_4; // R15
        default: postscale_divisor <= DIV_1; // R15
      endcase
      secondary_osc_on <= secondary_osc_enable_q; // R18
      secondary_is_devclk <= secondary_osc_enable_q && (current_osc_group_q == GRP_LPXT); // R22
      // Failure path never touches this, so the watchdog keeps its clock
      low_power_rc_osc_run <= !sync2_q.sleep_mode && (!cfg_loaded_q || mon_en || soft_watchdog_enable
          || (current_osc_group_q == GRP_LOW_POWER_RC_OSC)); // R01 R04
      clk_fail_trap <= fail_evt; // R02
      rc_trim_out <= $signed(rc_trim_field_q); // R20
    end
  end

  AST_LOW_POWER_RC_OSC_MON: assert property (mon_en && !sync2_q.sleep_mode |=> low_power_rc_osc_run) // R01
    else $error("Low-power RC stopped while monitor enabled");
  AST_POSTDIV: assert property (##1 (postscale_divisor ==
      (($past(clock_postscale_sel_q) == CLOCK_POSTSCALE_SEL_DIV64) ? DIV_64 : ($past(clock_postscale_sel_q) == CLOCK_POSTSCALE_SEL_DIV16) ? DIV_16 :
      ($past(clock_postscale_sel_q) == CLOCK_POSTSCALE_SEL_DIV4) ? DIV_4 : DIV_1))) // R15
    else $error("Postscale divisor does not match code");
  COV_CLOCK_FAIL: cover property (fail_clk ##[1:4] (apb_rsp.pready && lo_wr));

endmodule

`default_nettype wire

// ### cswm_osc_model.sv
// Behavioural oscillator sources and trap counter on the far side of the clock switch
`timescale 1ns/1ps
`default_nettype none
module cswm_osc_model
  import cswm_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Scenario controls
  input wire logic sys_run,
  input wire logic [7:0] ready_dly,
  input wire logic started,
  input wire logic power_up_timer,
  // Block outputs
  input wire logic busy,
  input wire logic [GRP_W-1:0] group,
  input wire logic trap,
  // Pins and trap count
  output cswm_osc_pins_t osc_pins,
  output logic [7:0] n_traps
);
  logic sys_q = 1'b0;
  logic low_power_rc_osc_q = 1'b0;
  logic [1:0] div_q = 2'h0;
  logic [7:0] wait_q = 8'h00;
  logic ready_q = 1'b0;
  logic lock_q = 1'b0;
  // Counter kept internal so only one process writes it
  logic [7:0] traps_q = 8'h00;
  assign n_traps = traps_q;
  ////////////////////////////////////////////////////////////////////////////
  // A stopped source stops toggling, so the monitor sees no edges
  always_ff @(posedge mclk) begin
    if (sys_run) sys_q <= ~sys_q;
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3) low_power_rc_osc_q <= ~low_power_rc_osc_q;
    if (!busy) wait_q <= 8'h00;
    else if (wait_q != 8'hff) wait_q <= wait_q + 8'h01;
    // Slow start: a delay of ff never reports ready
    ready_q <= busy && (wait_q >= ready_dly) && (ready_dly != 8'hff);
    lock_q <= (group == GRP_PLL);
    if (trap) traps_q <= traps_q + 8'h01;
  end
  assign osc_pins = {sys_q, low_power_rc_osc_q, ready_q, started, lock_q, power_up_timer, 1'b0};
endmodule
`default_nettype wire

// ### cswm_top_tb_top.sv
// Register-level testbench for the clock switch and fail monitor
`timescale 1ns/1ps
`default_nettype none
module cswm_top_tb_top;
  import cswm_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  cswm_apb_req_t req;
  cswm_apb_rsp_t rsp;
  cswm_osc_pins_t pins;
  logic [1:0] smc, pss;
  logic [2:0] pgrp, grp, tgt;
  logic [4:0] pso;
  logic [6:0] div;
  logic [7:0] rdly, n_traps;
  logic sys_run, started, power_up_timer, busy, sec_on, sec_dev, low_power_rc_osc, trap, err;
  logic signed [3:0] trim;
  logic [31:0] rd;
  logic [6:0] dv [4] = '{7'h01, 7'h04, 7'h10, 7'h40};
  int errors = 0;
  int n_tests = 0;
  always #5 mclk = ~mclk;
  cswm_top #(.FAIL_WINDOW_TICKS(4)) DUT (.mclk(mclk), .arst_n(arst_n), .apb_req(req),
    .apb_rsp(rsp), .switch_monitor_cfg(smc), .poweron_group_cfg(pgrp),
    .primary_select_cfg(5'h05), .soft_watchdog_enable(1'b0), .osc_pins(pins),
    .osc_group_sel(grp), .target_osc_group(tgt), .primary_select_out(pso),
    .osc_switch_busy(busy), .clock_postscale_sel(pss), .postscale_divisor(div),
    .secondary_osc_on(sec_on), .secondary_is_devclk(sec_dev), .low_power_rc_osc_run(low_power_rc_osc),
    .clk_fail_trap(trap), .rc_trim_out(trim));
  cswm_osc_model osc (.mclk(mclk), .sys_run(sys_run), .ready_dly(rdly), .started(started),
    .power_up_timer(power_up_timer), .busy(busy), .group(grp), .trap(trap), .osc_pins(pins), .n_traps(n_traps));
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    int i;
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
    @(posedge mclk);
    req.penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (rsp.pready === 1'b1) break;
    end
    if (i == 20) begin
      errors++;
      conclude();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  // Each byte lane has its own key pair; the third transfer is the write
  task automatic wlo(input logic [7:0] v);
    xfer(1'b1, OFS_OSC_CTRL, 32'h46, 4'h1);
    xfer(1'b1, OFS_OSC_CTRL, 32'h57, 4'h1);
    xfer(1'b1, OFS_OSC_CTRL, {24'h0, v}, 4'h1);
  endtask
  task automatic whi(input logic [7:0] v);
    xfer(1'b1, OFS_OSC_CTRL, 32'h7800, 4'h2);
    xfer(1'b1, OFS_OSC_CTRL, 32'h9a00, 4'h2);
    xfer(1'b1, OFS_OSC_CTRL, {16'h0, v, 8'h0}, 4'h2);
  endtask
  task automatic rdc(input logic [31:0] exp);
    xfer(1'b0, OFS_OSC_CTRL, 32'h0, 4'h0);
    check("ctrl", rd, exp);
  endtask
  task automatic wait_on(input logic for_trap);
    int i;
    repeat (3) @(posedge mclk);
    for (i = 0; i < 300; i++) begin
      if (for_trap ? trap === 1'b1 : busy === 1'b0) break;
      @(posedge mclk);
    end
    if (i == 300) begin
      errors++;
      conclude();
    end
    repeat (3) @(posedge mclk);
  endtask
  task automatic rst(input logic [1:0] c, input logic [2:0] g);
    @(posedge mclk);
    arst_n <= 1'b0;
    smc <= c;
    pgrp <= g;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    req = '0;
    smc = 2'h0;
    pgrp = GRP_EXT;
    sys_run = 1'b1;
    started = 1'b1;
    power_up_timer = 1'b0;
    rdly = 8'h02;
    rst(2'h0, GRP_EXT);
    rdc(32'h3300);
    check("tgt", 32'(tgt), 32'(GRP_EXT));
    check("prim", 32'(pso), 32'h5);
    xfer(1'b1, OFS_OSC_CTRL, 32'hff, 4'h1);
    rdc(32'h3300);
    for (int p = 0; p < 4; p++) begin
      wlo({p[1:0], 6'h02});
      repeat (2) @(posedge mclk);
      check("div", 32'(div), 32'(dv[p]));
    end
    check("sec", 32'(sec_on), 32'h1);
    rdc(32'h33c2);
    check("pss", 32'(pss), 32'h3);
    whi(8'h07);
    wlo(8'hc3);
    wait_on(1'b0);
    rdc(32'h77e2);
    wlo(8'hc3);
    repeat (6) @(posedge mclk);
    rdc(32'h77e2);
    // Abort while the target never reports ready
    rdly <= 8'hff;
    whi(8'h00);
    wlo(8'hc3);
    repeat (4) @(posedge mclk);
    check("busy", 32'(busy), 32'h1);
    wlo(8'hc2);
    repeat (4) @(posedge mclk);
    check("busy", 32'(busy), 32'h0);
    check("grp", 32'(grp), 32'(GRP_PLL));
    rdly <= 8'h02;
    sys_run <= 1'b0;
    wait_on(1'b1);
    sys_run <= 1'b1;
    check("traps", 32'(n_traps), 32'h1);
    check("low_power_rc_osc", 32'(low_power_rc_osc), 32'h1);
    check("grp", 32'(grp), 32'(GRP_FRC));
    rdc(32'h10ca);
    whi(8'h03);
    // Fail bit written as one, so only the switch start can clear it
    wlo(8'hcb);
    wait_on(1'b0);
    rdc(32'h33c2);
    xfer(1'b1, OFS_RC_TRIM, 32'h8, 4'h1);
    xfer(1'b0, OFS_RC_TRIM, 32'h0, 4'h0);
    check("trim", rd, 32'h8);
    check("trimo", 32'(trim), 32'hfffffff8);
    xfer(1'b0, 12'h008, 32'h0, 4'h0);
    check("err", 32'(err), 32'h1);
    check("rd", rd, 32'h0);
    // Oscillator still silent when the power-up timer runs out
    started <= 1'b0;
    rst(2'h0, GRP_EXT);
    repeat (4) @(posedge mclk);
    power_up_timer <= 1'b1;
    wait_on(1'b1);
    check("traps", 32'(n_traps), 32'h2);
    check("grp", 32'(grp), 32'(GRP_FRC));
    power_up_timer <= 1'b0;
    started <= 1'b1;
    // Slow crystal group is only selected with the monitor off
    rst(2'h2, GRP_LPXT);
    whi(8'h07);
    wlo(8'h03);
    repeat (6) @(posedge mclk);
    rdc(32'h0702);
    check("grp", 32'(grp), 32'(GRP_LPXT));
    check("sdev", 32'(sec_dev), 32'h1);
    check("low_power_rc_osc", 32'(low_power_rc_osc), 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
